// ### hdl/crossover_resolve.v
// Purpose: Resolve the crossover pair mapping from auto detection or override
// Assumes: Auto detection result is synchronous to the core clock
// Notes:   Result is registered
`timescale 1ns/10ps
module crossover_resolve (
  // Clock and reset
  input wire i_core_clk,
  input wire i_nrst,
  // Controls
  input wire i_force,
  input wire i_force_value,
  input wire i_auto_mdix,
  // Result
  output reg o_crossover_state
);

  // ****************************************************************
  // Crossover state register
  // ****************************************************************
  // Override picks the forced value, else the auto result is followed
  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_crossover_state <= 1'b0;
    end else if (i_force) begin
      o_crossover_state <= i_force_value;
    end else begin
      o_crossover_state <= i_auto_mdix;
    end
  end

endmodule

// ### hdl/phy_vendor_config_defines.vh
// Purpose: Offsets, field positions and reset values of the vendor PHY registers
// Assumes: Management register numbers are 5 bits, data words are 16 bits
// Notes:   Definitions only
`ifndef PHY_VENDOR_CONFIG_DEFINES_VH
`define PHY_VENDOR_CONFIG_DEFINES_VH

// ****************************************************************
// Register numbers
// ****************************************************************
`define TENBASE_CONFIG_STATUS_OFS 5'h12
`define POWER_DOWN_SELECT_OFS 5'h13
`define SPECIFIED_CONFIGURATION_OFS 5'h14

// ****************************************************************
// Ten-base configuration and status fields
// ****************************************************************
`define TB_RESERVED_HI_BIT 15
`define TB_LINK_PULSE_BIT 14
`define TB_HEARTBEAT_BIT 13
`define TB_SQUELCH_BIT 12
`define TB_JABBER_BIT 11
`define TB_SPARE_A_BIT 10
`define TB_SPARE_B_BIT 1
`define TB_POLARITY_BIT 0
`define TB_LINK_PULSE_RST 1'h1
`define TB_HEARTBEAT_RST 1'h1
`define TB_SQUELCH_RST 1'h1
`define TB_JABBER_RST 1'h1
`define TB_SPARE_A_RST 1'h0
`define TB_SPARE_B_RST 1'h1

// ****************************************************************
// Power-down select fields
// ****************************************************************
`define PD_SEL_MSB 8
`define PD_SEL_RST 9'h000

// ****************************************************************
// Specified configuration fields
// ****************************************************************
`define SC_TEST_ONE_BIT 15
`define SC_TEST_TWO_BIT 14
`define SC_FORCE_SD_BIT 13
`define SC_TEST_THREE_BIT 12
`define SC_PREAMBLE_BIT 11
`define SC_TX_PWR_BIT 10
`define SC_AN_PWR_BIT 9
`define SC_RESERVED_BIT 8
`define SC_XOVER_STATE_BIT 7
`define SC_AN_LOOP_BIT 6
`define SC_XOVER_VALUE_BIT 5
`define SC_XOVER_FORCE_BIT 4
`define SC_MON_HIGH_BIT 3
`define SC_MON_LOW_BIT 2
`define SC_RMII_VER_BIT 1
`define SC_COMMON_POWER_DOWN_VALUE_BIT 0
`define SC_RW_RST 16'h0000

// ****************************************************************
// Preamble trimming counts
// ****************************************************************
`define PREAMBLE_CUT_LONG 4'ha
`define PREAMBLE_CUT_SHORT 4'h5
`define PREAMBLE_CUT_NONE 4'h0

`endif

// ### hdl/phy_vendor_config_regs.v
// Purpose: Vendor configuration and status registers 18, 19 and 20 of the PHY
// Assumes: Management port strobes are one-cycle pulses on i_core_clk
// Notes:   Read data is captured on the clock edge that takes the read strobe
`timescale 1ns/10ps
`include "phy_vendor_config_defines.vh"
module phy_vendor_config_regs #(
  parameter PD_COUNT = 9
) (
  // Clock and reset
  input wire i_core_clk,
  input wire i_nrst,
  // Management register port
  input wire [4:0] i_reg_addr,
  input wire i_reg_wr,
  input wire [15:0] i_reg_wdata,
  input wire i_reg_rd,
  output reg [15:0] o_reg_rdata,
  output reg o_reg_hit,
  // Status from the PHY datapath
  input wire i_speed_10m,
  input wire i_full_duplex,
  input wire i_rx_polarity_reversed,
  input wire i_signal_detect,
  input wire i_auto_mdix,
  input wire i_preamble_long_cut,
  // Ten-base controls
  output reg o_link_pulse_enable,
  output reg o_force_good_link,
  output reg o_heartbeat_active,
  output reg o_squelch_normal,
  output reg o_jabber_function_enable,
  // Power-down controls
  output reg [PD_COUNT-1:0] o_power_down,
  // Specified configuration controls
  output reg o_signal_detect,
  output reg o_preamble_reduce,
  output reg [3:0] o_preamble_cut_bits,
  output reg o_tx_10m_power_saving,
  output reg o_autoneg_power_saving,
  output reg o_autoneg_digital_loopback,
  output wire o_crossover_state,
  output reg [2:0] o_test_select,
  output reg [1:0] o_monitor_select,
  output reg o_rmii_version
);

  // ****************************************************************
  // Decode helper
  // ****************************************************************
  // True when the port address names the given register
  function is_reg;
    input [4:0] addr;
    input [4:0] num;
    begin
      is_reg = (addr == num);
    end
  endfunction

  // ****************************************************************
  // Storage
  // ****************************************************************
  reg link_pulse_enable; // Ten-base link pulses on
  reg heartbeat_enable; // Heartbeat on
  reg squelch_select; // Normal squelch when set
  reg jabber_function_enable; // Jabber on
  reg tb_spare_a; // Writable spare bit 10
  reg tb_spare_b; // Writable spare bit 1
  reg polarity_reversed_flag; // Receive polarity status
  reg [PD_COUNT-1:0] pd_select; // Per-circuit power-down selects
  reg test_select_one; // Vendor test select
  reg test_select_two; // Vendor test select
  reg test_select_three; // Vendor test select
  reg force_signal_detect; // Force 100M signal detect
  reg preamble_saving_enable; // Preamble trimming request
  reg tx_10m_power_saving; // 10M transmit power saving
  reg autoneg_power_saving_disable; // Inverted autoneg saving control
  reg autoneg_digital_loopback; // Autoneg loopback test
  reg crossover_force_value; // Forced pair mapping
  reg crossover_force; // Crossover override
  reg monitor_select_high; // Vendor monitor select
  reg monitor_select_low; // Vendor monitor select
  reg rmii_version; // RMII version select
  reg common_power_down_value; // Value applied to selected circuits
  reg [15:0] next_rdata; // Read word being assembled
  reg next_hit; // Register number is mapped
  wire wr_tb; // Write to register 18
  wire wr_pd; // Write to register 19
  wire wr_sc; // Write to register 20

  assign wr_tb = i_reg_wr && is_reg(i_reg_addr, `TENBASE_CONFIG_STATUS_OFS);
  assign wr_pd = i_reg_wr && is_reg(i_reg_addr, `POWER_DOWN_SELECT_OFS);
  assign wr_sc = i_reg_wr && is_reg(i_reg_addr, `SPECIFIED_CONFIGURATION_OFS);

  // ****************************************************************
  // Ten-base configuration register
  // ****************************************************************
  // Writable fields; bit 15 and bits 9..2 are not stored
  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      link_pulse_enable <= `TB_LINK_PULSE_RST;
      heartbeat_enable <= `TB_HEARTBEAT_RST;
      squelch_select <= `TB_SQUELCH_RST;
      jabber_function_enable <= `TB_JABBER_RST;
      tb_spare_a <= `TB_SPARE_A_RST;
      tb_spare_b <= `TB_SPARE_B_RST;
    end else if (wr_tb) begin
      link_pulse_enable <= i_reg_wdata[`TB_LINK_PULSE_BIT];
      heartbeat_enable <= i_reg_wdata[`TB_HEARTBEAT_BIT];
      squelch_select <= i_reg_wdata[`TB_SQUELCH_BIT];
      jabber_function_enable <= i_reg_wdata[`TB_JABBER_BIT];
      tb_spare_a <= i_reg_wdata[`TB_SPARE_A_BIT];
      tb_spare_b <= i_reg_wdata[`TB_SPARE_B_BIT];
    end
  end

  // Polarity status tracks the receive logic; writes never touch it
  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      polarity_reversed_flag <= 1'b0;
    end else begin
      polarity_reversed_flag <= i_rx_polarity_reversed;
    end
  end

  // ****************************************************************
  // Power-down select register
  // ****************************************************************
  // Only the low nine bits are stored; upper bits drop on write
  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pd_select <= `PD_SEL_RST;
    end else if (wr_pd) begin
      pd_select <= i_reg_wdata[`PD_SEL_MSB:0];
    end
  end

  // ****************************************************************
  // Specified configuration register
  // ****************************************************************
  // Reset word held as a constant so each field can be picked from it
  localparam [15:0] SC_RST = `SC_RW_RST;
  // Bit 8 and bit 7 are not writable
  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      test_select_one <= SC_RST[`SC_TEST_ONE_BIT];
      test_select_two <= SC_RST[`SC_TEST_TWO_BIT];
      force_signal_detect <= SC_RST[`SC_FORCE_SD_BIT];
      test_select_three <= SC_RST[`SC_TEST_THREE_BIT];
      preamble_saving_enable <= SC_RST[`SC_PREAMBLE_BIT];
      tx_10m_power_saving <= SC_RST[`SC_TX_PWR_BIT];
      autoneg_power_saving_disable <= SC_RST[`SC_AN_PWR_BIT];
      autoneg_digital_loopback <= SC_RST[`SC_AN_LOOP_BIT];
      crossover_force_value <= SC_RST[`SC_XOVER_VALUE_BIT];
      crossover_force <= SC_RST[`SC_XOVER_FORCE_BIT];
      monitor_select_high <= SC_RST[`SC_MON_HIGH_BIT];
      monitor_select_low <= SC_RST[`SC_MON_LOW_BIT];
      rmii_version <= SC_RST[`SC_RMII_VER_BIT];
      common_power_down_value <= SC_RST[`SC_COMMON_POWER_DOWN_VALUE_BIT];
    end else if (wr_sc) begin
      test_select_one <= i_reg_wdata[`SC_TEST_ONE_BIT];
      test_select_two <= i_reg_wdata[`SC_TEST_TWO_BIT];
      force_signal_detect <= i_reg_wdata[`SC_FORCE_SD_BIT];
      test_select_three <= i_reg_wdata[`SC_TEST_THREE_BIT];
      preamble_saving_enable <= i_reg_wdata[`SC_PREAMBLE_BIT];
      tx_10m_power_saving <= i_reg_wdata[`SC_TX_PWR_BIT];
      autoneg_power_saving_disable <= i_reg_wdata[`SC_AN_PWR_BIT];
      autoneg_digital_loopback <= i_reg_wdata[`SC_AN_LOOP_BIT];
      crossover_force_value <= i_reg_wdata[`SC_XOVER_VALUE_BIT];
      crossover_force <= i_reg_wdata[`SC_XOVER_FORCE_BIT];
      monitor_select_high <= i_reg_wdata[`SC_MON_HIGH_BIT];
      monitor_select_low <= i_reg_wdata[`SC_MON_LOW_BIT];
      rmii_version <= i_reg_wdata[`SC_RMII_VER_BIT];
      common_power_down_value <= i_reg_wdata[`SC_COMMON_POWER_DOWN_VALUE_BIT];
    end
  end

  // ****************************************************************
  // Crossover resolution
  // ****************************************************************
  crossover_resolve u_crossover (
    .i_core_clk(i_core_clk),
    .i_nrst(i_nrst),
    .i_force(crossover_force),
    .i_force_value(crossover_force_value),
    .i_auto_mdix(i_auto_mdix),
    .o_crossover_state(o_crossover_state)
  );

  // ****************************************************************
  // Read data assembly
  // ****************************************************************
  // Builds the read word for the addressed register, zero elsewhere
  always @* begin
    next_rdata = 16'h0000;
    next_hit = 1'b1;
    if (is_reg(i_reg_addr, `TENBASE_CONFIG_STATUS_OFS)) begin
      next_rdata[`TB_RESERVED_HI_BIT] = 1'b0;
      next_rdata[`TB_LINK_PULSE_BIT] = link_pulse_enable;
      next_rdata[`TB_HEARTBEAT_BIT] = heartbeat_enable;
      next_rdata[`TB_SQUELCH_BIT] = squelch_select;
      next_rdata[`TB_JABBER_BIT] = jabber_function_enable;
      next_rdata[`TB_SPARE_A_BIT] = tb_spare_a;
      next_rdata[`TB_SPARE_B_BIT] = tb_spare_b;
      next_rdata[`TB_POLARITY_BIT] = polarity_reversed_flag;
    end else if (is_reg(i_reg_addr, `POWER_DOWN_SELECT_OFS)) begin
      next_rdata[`PD_SEL_MSB:0] = pd_select;
    end else if (is_reg(i_reg_addr, `SPECIFIED_CONFIGURATION_OFS)) begin
      next_rdata[`SC_TEST_ONE_BIT] = test_select_one;
      next_rdata[`SC_TEST_TWO_BIT] = test_select_two;
      next_rdata[`SC_FORCE_SD_BIT] = force_signal_detect;
      next_rdata[`SC_TEST_THREE_BIT] = test_select_three;
      next_rdata[`SC_PREAMBLE_BIT] = preamble_saving_enable;
      next_rdata[`SC_TX_PWR_BIT] = tx_10m_power_saving;
      next_rdata[`SC_AN_PWR_BIT] = autoneg_power_saving_disable;
      next_rdata[`SC_RESERVED_BIT] = 1'b0;
      next_rdata[`SC_XOVER_STATE_BIT] = o_crossover_state;
      next_rdata[`SC_AN_LOOP_BIT] = autoneg_digital_loopback;
      next_rdata[`SC_XOVER_VALUE_BIT] = crossover_force_value;
      next_rdata[`SC_XOVER_FORCE_BIT] = crossover_force;
      next_rdata[`SC_MON_HIGH_BIT] = monitor_select_high;
      next_rdata[`SC_MON_LOW_BIT] = monitor_select_low;
      next_rdata[`SC_RMII_VER_BIT] = rmii_version;
      next_rdata[`SC_COMMON_POWER_DOWN_VALUE_BIT] = common_power_down_value;
    end else begin
      // Register numbers outside this bank answer zero, no hit
      next_hit = 1'b0;
    end
  end

  // Read data and hit flag are held until the next read strobe
  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_reg_rdata <= 16'h0000;
      o_reg_hit <= 1'b0;
    end else if (i_reg_rd) begin
      o_reg_rdata <= next_rdata;
      o_reg_hit <= next_hit;
    end
  end

  // ****************************************************************
  // Ten-base control outputs
  // ****************************************************************
  // Link pulses and forced link only steer 10M operation
  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_link_pulse_enable <= 1'b0;
      o_force_good_link <= 1'b0;
      o_heartbeat_active <= 1'b0;
      o_squelch_normal <= 1'b1;
      o_jabber_function_enable <= 1'b0;
    end else begin
      o_link_pulse_enable <= i_speed_10m && link_pulse_enable;
      o_force_good_link <= i_speed_10m && !link_pulse_enable;
      o_heartbeat_active <= heartbeat_enable && !i_full_duplex;
      o_squelch_normal <= squelch_select;
      o_jabber_function_enable <= jabber_function_enable;
    end
  end

  // ****************************************************************
  // Per-circuit power-down
  // ****************************************************************
  // Each selected circuit takes the common power-down value
  genvar gi;
  generate
    for (gi = 0; gi < PD_COUNT; gi = gi + 1) begin : g_pd
      always @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
          o_power_down[gi] <= 1'b0;
        end else begin
          o_power_down[gi] <= pd_select[gi] && common_power_down_value;
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Specified configuration control outputs
  // ****************************************************************
  // Signal detect override, preamble trimming, power saving, loopback
  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_signal_detect <= 1'b0;
      o_preamble_reduce <= 1'b0;
      o_preamble_cut_bits <= `PREAMBLE_CUT_NONE;
      o_tx_10m_power_saving <= 1'b0;
      o_autoneg_power_saving <= 1'b0;
      o_autoneg_digital_loopback <= 1'b0;
      o_test_select <= 3'h0;
      o_monitor_select <= 2'h0;
      o_rmii_version <= 1'b0;
    end else begin
      o_signal_detect <= force_signal_detect || i_signal_detect;
      o_preamble_reduce <= preamble_saving_enable && tx_10m_power_saving;
      if (preamble_saving_enable && tx_10m_power_saving) begin
        if (i_preamble_long_cut) begin
          o_preamble_cut_bits <= `PREAMBLE_CUT_LONG;
        end else begin
          o_preamble_cut_bits <= `PREAMBLE_CUT_SHORT;
        end
      end else begin
        o_preamble_cut_bits <= `PREAMBLE_CUT_NONE;
      end
      o_tx_10m_power_saving <= tx_10m_power_saving;
      o_autoneg_power_saving <= !autoneg_power_saving_disable;
      o_autoneg_digital_loopback <= autoneg_digital_loopback;
      o_test_select <= {test_select_three, test_select_two, test_select_one};
      o_monitor_select <= {monitor_select_high, monitor_select_low};
      o_rmii_version <= rmii_version;
    end
  end

endmodule

// ### tb/mgmt_host_model.sv
// Purpose: Management host that reads and writes the PHY registers
// Assumes: One-cycle strobes, taken at the rising clock edge
// Notes:   Address and data are inverted once released so stale values never match
`timescale 1ns/10ps
module mgmt_host_model (
  // Clock
  input wire i_core_clk,
  // Register port towards the block
  output reg [4:0] o_addr,
  output reg o_wr,
  output reg [15:0] o_wdata,
  output reg o_rd,
  input wire [15:0] i_rdata,
  input wire i_hit
);
  // Idle port at time zero
  initial begin
    o_addr = 5'h00;
    o_wr = 1'h0;
    o_wdata = 16'h0000;
    o_rd = 1'h0;
  end

  // One write strobe, released at the edge that takes it
  task wr_reg(input [4:0] a, input [15:0] d);
    begin
      @(posedge i_core_clk);
      o_addr <= a;
      o_wdata <= d;
      o_wr <= 1'h1;
      @(posedge i_core_clk);
      o_wr <= 1'h0;
      o_addr <= ~a;
      o_wdata <= ~d;
    end
  endtask

  // One read strobe, word taken once the capturing edge has settled
  task rd_reg(input [4:0] a, output [15:0] d, output h);
    begin
      @(posedge i_core_clk);
      o_addr <= a;
      o_rd <= 1'h1;
      @(posedge i_core_clk);
      o_rd <= 1'h0;
      o_addr <= ~a;
      #1;
      d = i_rdata;
      h = i_hit;
    end
  endtask
endmodule

// ### tb/phy_vendor_config_regs_props.sv
// Purpose: Port-level checks of the vendor PHY register block
// Assumes: Writable bits are mirrored from the management write port
// Notes:   Bound to every instance of the register block
`timescale 1ns/10ps
module phy_vendor_config_regs_props #(
  parameter PD_COUNT = 9
) (
  // Clock and reset
  input wire i_core_clk,
  input wire i_nrst,
  // Management port
  input wire [4:0] i_reg_addr,
  input wire i_reg_wr,
  input wire [15:0] i_reg_wdata,
  input wire i_reg_rd,
  input wire [15:0] o_reg_rdata,
  input wire o_reg_hit,
  // Status inputs
  input wire i_speed_10m,
  input wire i_full_duplex,
  input wire i_rx_polarity_reversed,
  input wire i_signal_detect,
  input wire i_auto_mdix,
  input wire i_preamble_long_cut,
  // Control outputs
  input wire o_link_pulse_enable,
  input wire o_force_good_link,
  input wire o_heartbeat_active,
  input wire o_squelch_normal,
  input wire o_jabber_function_enable,
  input wire [PD_COUNT-1:0] o_power_down,
  input wire o_signal_detect,
  input wire o_preamble_reduce,
  input wire [3:0] o_preamble_cut_bits,
  input wire o_tx_10m_power_saving,
  input wire o_autoneg_power_saving,
  input wire o_autoneg_digital_loopback,
  input wire o_crossover_state
);
  // ****************************************************************
  // Shadow registers
  // ****************************************************************
  reg [1:0] up; // Edges seen since reset release
  reg [15:0] sh18, sh19, sh20; // Writable bits as the host left them
  reg [15:0] d18, d19, d20; // Shadows one cycle late, match output timing

  // Mirror writes; read-only bits stay zero in the shadow
  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      up <= 2'h0;
      sh18 <= 16'h7802;
      sh19 <= 16'h0000;
      sh20 <= 16'h0000;
    end else begin
      up <= {up[0], 1'h1};
      if (i_reg_wr && i_reg_addr == 5'h12) begin
        sh18 <= i_reg_wdata & 16'h7c02;
      end
      if (i_reg_wr && i_reg_addr == 5'h13) begin
        sh19 <= i_reg_wdata & 16'h01ff;
      end
      if (i_reg_wr && i_reg_addr == 5'h14) begin
        sh20 <= i_reg_wdata & 16'hfe7f;
      end
    end
  end

  // Delayed copies, no reset needed: they follow reset values in reset
  always @(posedge i_core_clk) begin
    d18 <= sh18;
    d19 <= sh19;
    d20 <= sh20;
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_link_pulse_gate: assert property (up[0] |->
    o_link_pulse_enable == ($past(i_speed_10m) & d18[14]) &&
    o_force_good_link == ($past(i_speed_10m) & ~d18[14]))
    else $error("link pulse control wrong");
  a_heartbeat_duplex: assert property (up[0] |->
    o_heartbeat_active == (d18[13] & ~$past(i_full_duplex)))
    else $error("heartbeat control wrong");
  a_squelch_jabber: assert property (up[0] |->
    o_squelch_normal == d18[12] && o_jabber_function_enable == d18[11])
    else $error("squelch or jabber control wrong");
  a_tenbase_read: assert property (i_reg_rd && i_reg_addr == 5'h12 && up[1] |=>
    o_reg_rdata[15:1] == d18[15:1] && o_reg_rdata[0] == $past(i_rx_polarity_reversed, 2))
    else $error("ten-base register read wrong");
  a_pd_select_read: assert property (i_reg_rd && i_reg_addr == 5'h13 |=>
    o_reg_rdata == d19 && o_reg_hit)
    else $error("power-down select read wrong");
  a_power_down_apply: assert property (up[0] |->
    o_power_down == (d19[PD_COUNT-1:0] & {PD_COUNT{d20[0]}}))
    else $error("power-down outputs wrong");
  a_signal_force: assert property (up[0] |->
    o_signal_detect == (d20[13] | $past(i_signal_detect)))
    else $error("signal detect output wrong");
  a_preamble_count: assert property (up[0] |->
    o_preamble_reduce == (d20[11] & d20[10]) && o_preamble_cut_bits ==
    ((d20[11] & d20[10]) ? ($past(i_preamble_long_cut) ? 4'ha : 4'h5) : 4'h0))
    else $error("preamble trimming wrong");
  a_saving_loop: assert property (up[0] |-> o_tx_10m_power_saving == d20[10] &&
    o_autoneg_power_saving == ~d20[9] && o_autoneg_digital_loopback == d20[6])
    else $error("power saving or loopback wrong");
  a_crossover_pick: assert property (up[0] |->
    o_crossover_state == (d20[4] ? d20[5] : $past(i_auto_mdix)))
    else $error("crossover state wrong");
  a_config_read: assert property (i_reg_rd && i_reg_addr == 5'h14 |=>
    o_reg_rdata == (d20 | {8'h00, $past(o_crossover_state), 7'h00}))
    else $error("configuration read wrong");
  a_unmapped_read: assert property (i_reg_rd && (i_reg_addr < 5'h12 || i_reg_addr > 5'h14)
    |=> o_reg_rdata == 16'h0000 && !o_reg_hit)
    else $error("unmapped read not refused");

  // Main scenarios reached
  c_long_cut: cover property (o_preamble_cut_bits == 4'ha);
  c_forced_xover: cover property (d20[4] && o_crossover_state);
  c_all_pd: cover property (&o_power_down);
endmodule

bind phy_vendor_config_regs phy_vendor_config_regs_props #(.PD_COUNT(PD_COUNT)) i_props (.*);

// ### tb/phy_vendor_config_regs_test.sv
// Purpose: Directed register and control tests of the vendor PHY block
// Assumes: Control outputs settle one edge after a write is taken or an input changes
// Notes:   Host accesses go through the management host model
`timescale 1ns/10ps
module phy_vendor_config_regs_test;
  // Clock, reset and datapath status
  reg i_core_clk = 1'h0;
  reg i_nrst = 1'h0;
  reg i_speed_10m = 1'h1;
  reg i_full_duplex = 1'h0;
  reg i_rx_polarity_reversed = 1'h0;
  reg i_signal_detect = 1'h0;
  reg i_auto_mdix = 1'h0;
  reg i_preamble_long_cut = 1'h0;
  wire [4:0] i_reg_addr;
  wire i_reg_wr, i_reg_rd, o_reg_hit;
  wire [15:0] i_reg_wdata, o_reg_rdata;
  wire o_link_pulse_enable, o_force_good_link, o_heartbeat_active;
  wire o_squelch_normal, o_jabber_function_enable, o_signal_detect, o_preamble_reduce;
  wire o_tx_10m_power_saving, o_autoneg_power_saving, o_autoneg_digital_loopback;
  wire o_crossover_state, o_rmii_version;
  wire [8:0] o_power_down;
  wire [3:0] o_preamble_cut_bits;
  wire [2:0] o_test_select;
  wire [1:0] o_monitor_select;
  integer err_count = 0;
  integer total_checks = 0;
  integer cycles = 0;
  integer k;
  reg [15:0] rd_val;
  reg rd_hit;

  always #20 i_core_clk = ~i_core_clk;

  mgmt_host_model i_host (.i_core_clk(i_core_clk), .o_addr(i_reg_addr), .o_wr(i_reg_wr),
    .o_wdata(i_reg_wdata), .o_rd(i_reg_rd), .i_rdata(o_reg_rdata), .i_hit(o_reg_hit));

  // Every port meets the bench signal of the same name
  phy_vendor_config_regs #(.PD_COUNT(9)) i_dut (.*);

  // Compare one value, count it, report a difference at once
  task chk(input [8*12:1] n, input [15:0] e, input [15:0] g);
    begin
      total_checks = total_checks + 1;
      if (g !== e) begin
        $display("mismatch %0s expected %h seen %h", n, e, g);
        err_count = err_count + 1;
      end
    end
  endtask

  // Read a register and compare word and hit flag
  task rdchk(input [4:0] a, input [15:0] e);
    begin
      i_host.rd_reg(a, rd_val, rd_hit);
      chk("read data", e, rd_val);
      chk("read hit", {15'h0000, a >= 5'h12 && a <= 5'h14}, {15'h0000, rd_hit});
    end
  endtask

  // Let registered controls catch up with the last change
  task settle;
    begin
      repeat (3) @(posedge i_core_clk);
      #1;
    end
  endtask

  task stop_test;
    begin
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
        $display("Finished cleanly");
      end else begin
        $display("Finished with errors");
      end
      $finish;
    end
  endtask

  // Hang guard, far above the length of the sequence
  always @(posedge i_core_clk) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      err_count = err_count + 1;
      stop_test;
    end
  end

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    repeat (8) @(posedge i_core_clk);
    i_nrst <= 1'h1;
    rdchk(5'h12, 16'h7802);
    rdchk(5'h13, 16'h0000);
    rdchk(5'h14, 16'h0000);
    chk("squelch", 1'h1, o_squelch_normal);
    chk("heartbeat", 1'h1, o_heartbeat_active);
    chk("link pulse", 1'h1, o_link_pulse_enable);
    $display("test reset values done");
    i_host.wr_reg(5'h12, 16'hffff);
    rdchk(5'h12, 16'h7c02);
    i_host.wr_reg(5'h12, 16'h0000);
    settle;
    chk("link pulse", 1'h0, o_link_pulse_enable);
    chk("good link", 1'h1, o_force_good_link);
    chk("heartbeat", 1'h0, o_heartbeat_active);
    chk("squelch", 1'h0, o_squelch_normal);
    chk("jabber", 1'h0, o_jabber_function_enable);
    @(posedge i_core_clk);
    i_speed_10m <= 1'h0;
    settle;
    chk("good link", 1'h0, o_force_good_link);
    i_host.wr_reg(5'h12, 16'h7802);
    @(posedge i_core_clk);
    i_full_duplex <= 1'h1;
    i_rx_polarity_reversed <= 1'h1;
    settle;
    chk("heartbeat", 1'h0, o_heartbeat_active);
    rdchk(5'h12, 16'h7803);
    $display("test ten-base controls done");
    i_host.wr_reg(5'h13, 16'hffff);
    rdchk(5'h13, 16'h01ff);
    settle;
    chk("power down", 16'h0000, o_power_down);
    i_host.wr_reg(5'h14, 16'h0001);
    settle;
    chk("power down", 16'h01ff, o_power_down);
    i_host.wr_reg(5'h13, 16'h0105);
    settle;
    chk("power down", 16'h0105, o_power_down);
    i_host.wr_reg(5'h14, 16'h2000);
    settle;
    chk("sig detect", 1'h1, o_signal_detect);
    $display("test power down and detect done");
    for (k = 0; k < 8; k = k + 1) begin
      i_host.wr_reg(5'h14, {4'h0, k[2], k[1], 10'h000});
      @(posedge i_core_clk);
      i_preamble_long_cut <= k[0];
      settle;
      chk("cut bits", (k[2] && k[1]) ? (k[0] ? 16'h000a : 16'h0005) : 16'h0000,
        o_preamble_cut_bits);
      chk("tx saving", k[1], o_tx_10m_power_saving);
      chk("reduce", k[2] && k[1], o_preamble_reduce);
      chk("sig detect", 1'h0, o_signal_detect);
    end
    i_host.wr_reg(5'h14, 16'h0240);
    settle;
    chk("an saving", 1'h0, o_autoneg_power_saving);
    chk("an loopback", 1'h1, o_autoneg_digital_loopback);
    $display("test preamble and saving done");
    @(posedge i_core_clk);
    i_auto_mdix <= 1'h1;
    i_host.wr_reg(5'h14, 16'h0000);
    settle;
    chk("crossover", 1'h1, o_crossover_state);
    rdchk(5'h14, 16'h0080);
    i_host.wr_reg(5'h14, 16'h0010);
    settle;
    chk("crossover", 1'h0, o_crossover_state);
    @(posedge i_core_clk);
    i_auto_mdix <= 1'h0;
    i_host.wr_reg(5'h14, 16'h0030);
    settle;
    chk("crossover", 1'h1, o_crossover_state);
    i_host.wr_reg(5'h14, 16'hffff);
    settle;
    rdchk(5'h14, 16'hfeff);
    chk("test select", 16'h0007, o_test_select);
    chk("monitor sel", 16'h0003, o_monitor_select);
    chk("rmii version", 16'h0001, o_rmii_version);
    $display("test crossover done");
    i_host.wr_reg(5'h15, 16'hffff);
    rdchk(5'h15, 16'h0000);
    rdchk(5'h1d, 16'h0000);
    rdchk(5'h12, 16'h7803);
    $display("test unmapped access done");
    stop_test;
  end
endmodule
